// ===== design/net_host_consts.vh
// constants for the backplane handshake block of the network module
`ifndef NET_HOST_CONSTS_VH
`define NET_HOST_CONSTS_VH

// clock and power-up check timing
`define CLK_KHZ 100000
`define INIT_TIME_MS 1000
`define INIT_CYCLES (`INIT_TIME_MS * `CLK_KHZ)

// message limits
`define MSG_MAX_BYTES 11'h0400

// request channel indices
`define CH_SEND 0
`define CH_PWR 1
`define CH_PRD 2
`define CH_PROF 3
`define CH_LCLR 4
`define CH_LRD 5
`define N_CH 6

// input word bit positions (device to cpu)
`define X_SEND_OK 0
`define X_SEND_FAIL 1
`define X_RX_PEND 2
`define X_PWR_DONE 16
`define X_PRD_DONE 17
`define X_PROF_DONE 19
`define X_LCLR_DONE 20
`define X_LRD_DONE 21
`define X_PARAM_ERR 24
`define X_TOKEN 25
`define X_READY 28
`define X_WDT 31

// output word bit positions (cpu to device)
`define Y_SEND 0
`define Y_RX_ACK 2
`define Y_PWR 16
`define Y_PRD 17
`define Y_PROF 19
`define Y_LCLR 20
`define Y_LRD 21

// register word indices (wishbone address bits 5:2)
`define REG_STATUS 4'h0
`define REG_DONE 4'h1
`define REG_FLAGS 4'h2
`define REG_RX 4'h3
`define REG_MSG 4'h4

// field positions
`define DONE_FAIL_LSB 8
`define ST_RX_LSB 8
`define ST_READY 9
`define ST_ECHO 10
`define ST_TIMER 11
`define FL_PERR 0
`define FL_TOKEN 1
`define FL_WDT 2
`define FL_CHECK 3
`define RX_SET 0
`define RX_ECHO 1
`define MSG_WORD 16
`define MSG_ECHO_EN 17

// reset values
`define FLAGS_RST 4'h0
`define MSG_RST 18'h0_0000

`endif

// ===== design/req_hs.v
// one request/completion handshake channel
`timescale 1ns/1ps
module req_hs
(
    input wire sys_clk,
    input wire rst,
    input wire clk_en,
    input wire req,
    input wire ok_p,
    input wire fail_p,
    output wire busy,
    output reg ok_r,
    output reg fail_r
);
    localparam IDLE = 2'd0;
    localparam BUSY = 2'd1;
    localparam DONE = 2'd2;

    reg [1:0] st_r;

    assign busy = (st_r == BUSY);

    // a request seen high in idle starts work, completion holds until cpu withdraws
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            st_r <= IDLE;
            ok_r <= 1'b0;
            fail_r <= 1'b0;
        end
        else if (clk_en)
        begin
            case (st_r)
                IDLE:
                begin
                    if (req)
                        st_r <= BUSY;
                end
                BUSY:
                begin
                    // fail outranks ok if both come together
                    if (fail_p)
                    begin
                        fail_r <= 1'b1;
                        st_r <= DONE;
                    end
                    else if (ok_p)
                    begin
                        ok_r <= 1'b1;
                        st_r <= DONE;
                    end
                end
                DONE:
                begin
                    // a request held on keeps the answer standing
                    if (!req)
                    begin
                        ok_r <= 1'b0;
                        fail_r <= 1'b0;
                        st_r <= IDLE;
                    end
                end
                default:
                    st_r <= IDLE;
            endcase
        end
    end
endmodule // req_hs

// ===== design/net_host_if.v
// backplane request/completion interface with wishbone side for firmware
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "net_host_consts.vh"
module net_host_if
#(
    parameter INIT_CYCLES = `INIT_CYCLES
)
(
    input wire sys_clk,
    input wire rst,
    input wire clk_en,
    input wire [31:0] y_bits,
    output wire [31:0] x_bits,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o
);
    // backplane bits synchronised
    reg [31:0] y_meta_r;
    reg [31:0] y_sync_r;

    // init timer
    reg [31:0] init_cnt_r;
    reg init_done_r;

    // firmware-set state
    reg [3:0] flags_r;
    reg [17:0] msg_r;
    reg rx_pend_r;
    reg echo_pend_r;

    // completion strobes from firmware writes
    reg [`N_CH-1:0] ok_p_r;
    reg [`N_CH-1:0] fail_p_r;

    wire [`N_CH-1:0] req;
    wire [`N_CH-1:0] busy;
    wire [`N_CH-1:0] ok;
    wire [`N_CH-1:0] fail;
    wire [`N_CH-1:0] fail_in;
    wire len_bad;
    wire ready;
    wire wb_req;
    wire wb_wr;
    wire [3:0] wb_idx;
    reg [31:0] rd_data;

    // cpu bits come from another module; two stages before use
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            y_meta_r <= 32'h0000_0000;
            y_sync_r <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            y_meta_r <= y_bits;
            y_sync_r <= y_meta_r;
        end
    end

    // only documented request bits are looked at
    assign req[`CH_SEND] = y_sync_r[`Y_SEND];
    assign req[`CH_PWR] = y_sync_r[`Y_PWR];
    assign req[`CH_PRD] = y_sync_r[`Y_PRD];
    assign req[`CH_PROF] = y_sync_r[`Y_PROF];
    assign req[`CH_LCLR] = y_sync_r[`Y_LCLR];
    assign req[`CH_LRD] = y_sync_r[`Y_LRD];

    // payload checks on the send channel
    assign len_bad = (msg_r[10:0] > `MSG_MAX_BYTES)
        | (msg_r[`MSG_WORD] & msg_r[0]);

    // a bad send fails at once, others only by firmware
    assign fail_in[`CH_SEND] = fail_p_r[`CH_SEND] | len_bad;
    assign fail_in[`N_CH-1:1] = fail_p_r[`N_CH-1:1];

    // one handshake channel per request pair
    genvar g;
    generate
        for (g = 0; g < `N_CH; g = g + 1)
        begin : ch
            req_hs u_hs
            (
                .sys_clk(sys_clk),
                .rst(rst),
                .clk_en(clk_en),
                .req(req[g]),
                .ok_p(ok_p_r[g]),
                .fail_p(fail_in[g]),
                .busy(busy[g]),
                .ok_r(ok[g]),
                .fail_r(fail[g])
            );
        end
    endgenerate

    // power-up check window; parameter lets simulation shorten it
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            init_cnt_r <= 32'h0000_0000;
            init_done_r <= 1'b0;
        end
        else if (clk_en && !init_done_r)
        begin
            if (init_cnt_r == INIT_CYCLES - 1)
                init_done_r <= 1'b1;
            else
                init_cnt_r <= init_cnt_r + 32'h0000_0001;
        end
    end

    // ready only after the window and a passed check
    assign ready = init_done_r & flags_r[`FL_CHECK]
        & ~flags_r[`FL_WDT];

    // input word; prohibited bits stay low
    assign x_bits[`X_SEND_OK] = ok[`CH_SEND];
    assign x_bits[`X_SEND_FAIL] = fail[`CH_SEND];
    assign x_bits[`X_RX_PEND] = rx_pend_r;
    assign x_bits[15:3] = 13'h0000;
    // other channels report done on ok or fail alike
    assign x_bits[`X_PWR_DONE] = ok[`CH_PWR] | fail[`CH_PWR];
    assign x_bits[`X_PRD_DONE] = ok[`CH_PRD] | fail[`CH_PRD];
    assign x_bits[18] = 1'b0;
    assign x_bits[`X_PROF_DONE] = ok[`CH_PROF] | fail[`CH_PROF];
    assign x_bits[`X_LCLR_DONE] = ok[`CH_LCLR] | fail[`CH_LCLR];
    assign x_bits[`X_LRD_DONE] = ok[`CH_LRD] | fail[`CH_LRD];
    assign x_bits[23:22] = 2'h0;
    assign x_bits[`X_PARAM_ERR] = flags_r[`FL_PERR];
    assign x_bits[`X_TOKEN] = flags_r[`FL_TOKEN];
    assign x_bits[27:26] = 2'h0;
    assign x_bits[`X_READY] = ready;
    assign x_bits[30:29] = 2'h0;
    assign x_bits[`X_WDT] = flags_r[`FL_WDT];

    // bus decode: a write is taken when ack is already up
    assign wb_req = wb_cyc_i & wb_stb_i;
    assign wb_wr = wb_req & wb_we_i & wb_ack_o;
    assign wb_idx = wb_adr_i[5:2];

    // read mux; unmapped offsets read zero
    always @*
    begin
        rd_data = 32'h0000_0000;
        if (wb_adr_i[7:6] == 2'b00)
        begin
            case (wb_idx)
                `REG_STATUS:
                begin
                    rd_data[`N_CH-1:0] = busy;
                    rd_data[`ST_RX_LSB] = rx_pend_r;
                    rd_data[`ST_READY] = ready;
                    rd_data[`ST_ECHO] = echo_pend_r;
                    rd_data[`ST_TIMER] = init_done_r;
                end
                `REG_FLAGS:
                    rd_data[3:0] = flags_r;
                `REG_RX:
                begin
                    rd_data[`RX_SET] = rx_pend_r;
                    rd_data[`RX_ECHO] = echo_pend_r;
                end
                `REG_MSG:
                    rd_data[17:0] = msg_r;
                default:
                    rd_data = 32'h0000_0000;
            endcase
        end
    end

    // ack one cycle after the request, dropped the cycle after
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (clk_en)
        begin
            wb_ack_o <= wb_req & ~wb_ack_o;
            if (wb_req & ~wb_ack_o & ~wb_we_i)
                wb_dat_o <= rd_data;
        end
    end

    // control registers written at the acked edge
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            flags_r <= `FLAGS_RST;
            msg_r <= `MSG_RST;
        end
        else if (clk_en && wb_wr && wb_adr_i[7:6] == 2'b00)
        begin
            if (wb_idx == `REG_FLAGS && wb_sel_i[0])
                flags_r <= wb_dat_i[3:0];
            if (wb_idx == `REG_MSG)
            begin
                if (wb_sel_i[0])
                    msg_r[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[1])
                    msg_r[10:8] <= wb_dat_i[10:8];
                if (wb_sel_i[2])
                    msg_r[17:16] <= wb_dat_i[17:16];
            end
        end
    end

    // completion strobes: one cycle wide, from the done register
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ok_p_r <= {`N_CH{1'b0}};
            fail_p_r <= {`N_CH{1'b0}};
        end
        else if (clk_en)
        begin
            ok_p_r <= {`N_CH{1'b0}};
            fail_p_r <= {`N_CH{1'b0}};
            if (wb_wr && wb_adr_i[7:6] == 2'b00 && wb_idx == `REG_DONE)
            begin
                if (wb_sel_i[0])
                    ok_p_r <= wb_dat_i[`N_CH-1:0];
                if (wb_sel_i[1])
                    fail_p_r <= wb_dat_i[`DONE_FAIL_LSB+`N_CH-1:`DONE_FAIL_LSB];
            end
        end
    end

    // received flag: set by firmware, cleared by cpu confirm; set wins
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            rx_pend_r <= 1'b0;
        else if (clk_en)
        begin
            if (wb_wr && wb_adr_i[7:6] == 2'b00 && wb_idx == `REG_RX
                && wb_sel_i[0] && wb_dat_i[`RX_SET])
                rx_pend_r <= 1'b1;
            else if (y_sync_r[`Y_RX_ACK])
                rx_pend_r <= 1'b0;
        end
    end

    // return command: echo is owed to the sender until firmware sends it
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            echo_pend_r <= 1'b0;
        else if (clk_en)
        begin
            if (wb_wr && wb_adr_i[7:6] == 2'b00 && wb_idx == `REG_RX
                && wb_sel_i[0] && wb_dat_i[`RX_ECHO] && msg_r[`MSG_ECHO_EN])
                echo_pend_r <= 1'b1;
            else if (wb_wr && wb_adr_i[7:6] == 2'b00 && wb_idx == `REG_DONE
                && wb_sel_i[2] && wb_dat_i[16])
                echo_pend_r <= 1'b0;
        end
    end
endmodule // net_host_if

// ===== verification/net_host_sva.sv
// concurrent checks on the backplane words of the network host block
`timescale 1ns/1ps
module net_host_sva
(
    input wire sys_clk,
    input wire rst,
    input wire clk_en,
    input wire [31:0] y_bits,
    input wire [31:0] x_bits,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire wb_ack_o
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // unused input bits must stay dark
    chk_unused_zero: assert property ((x_bits & ~32'h933b_0007) == 32'h0000_0000)
        else $error("unused input bit driven");
    chk_send_excl: assert property (!(x_bits[0] && x_bits[1]))
        else $error("send ok and fail together");
    // sync stages plus one edge bound the release
    chk_send_drop: assert property (!y_bits[0] [*5] |-> !x_bits[0] && !x_bits[1])
        else $error("send completion outlives request");
    chk_pwr_drop: assert property (!y_bits[16] [*5] |-> !x_bits[16])
        else $error("write completion outlives request");
    chk_prd_cause: assert property ($rose(x_bits[17]) |-> $past(y_bits[17], 2))
        else $error("read completion without request");
    // a frozen block may hold pending while confirm stands, so count enabled cycles only
    chk_rx_clear: assert property ((y_bits[2] && clk_en) [*5] |-> !x_bits[2])
        else $error("rx pending ignores confirmation");
    chk_init_dark: assert property ($fell(rst) |-> !x_bits[28] [*8])
        else $error("ready during initialization");
    // flag writes show on the word one cycle after the ack edge and are checked two cycles after
    chk_perr_flag: assert property (wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h02
        |-> ##2 x_bits[24] == $past(wb_dat_i[0], 2))
        else $error("param error flag mismatch");
    chk_token_flag: assert property (wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h02
        |-> ##2 x_bits[25] == $past(wb_dat_i[1], 2))
        else $error("token flag mismatch");
    chk_wdt_flag: assert property (wb_ack_o && wb_we_i && wb_adr_i[7:2] == 6'h02
        |-> ##2 x_bits[31] == $past(wb_dat_i[2], 2))
        else $error("watchdog flag mismatch");
endmodule // net_host_sva

// ===== verification/cpu_model.sv
// controller cpu model driving the output word
`timescale 1ns/1ps
module cpu_model
(
    input wire sys_clk,
    input wire [31:0] x_bits,
    output logic [31:0] y_bits
);
    // only listed request bits are ever raised
    initial y_bits = 32'h0000_0000;
    // hold request until the answer, then drop; bounded so a dead device is seen
    task automatic run(input int rb, input logic [31:0] cm, input logic want,
        output logic [31:0] seen);
        int n;
        @(posedge sys_clk);
        y_bits[rb] <= 1'b1;
        for (n = 0; n < 200 && (|(x_bits & cm)) !== want; n++)
            @(posedge sys_clk);
        seen = x_bits & cm;
        y_bits[rb] <= 1'b0;
        for (n = 0; n < 200 && (x_bits & cm) !== 32'h0000_0000; n++)
            @(posedge sys_clk);
    endtask
endmodule // cpu_model

// ===== verification/testbench.sv
// self-checking bench for the network module backplane handshake
`timescale 1ns/1ps
module testbench;
    logic sys_clk, rst, clk_en, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, q, seen, ex;
    wire [31:0] x_bits, y_bits, wb_dat_o;
    wire wb_ack_o;
    int err_total = 0, cmp_count = 0, k, f, rb;
    // request bit of each channel, in channel order
    int rbit[6] = '{0, 16, 17, 19, 20, 21};
    logic [31:0] bad[2] = '{32'h0000_0401, 32'h0001_0007};
    net_host_if #(.INIT_CYCLES(20)) net_host_if_inst (.sys_clk, .rst, .clk_en, .y_bits,
        .x_bits, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o);
    cpu_model cpu_model_inst (.sys_clk, .x_bits, .y_bits);
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task give_verdict;
        $display("errors %0d checks %0d", err_total, cmp_count);
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, g);
        cmp_count++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask
    // classic single cycle; a missing ack ends the run
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= a;
        wb_dat_i <= d;
        for (n = 0; n < 20; n++)
        begin
            @(posedge sys_clk);
            if (wb_ack_o === 1'b1)
                break;
        end
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge sys_clk);
        if (n == 20)
        begin
            err_total++;
            give_verdict;
        end
    endtask
    task wait_x(input string nm, input logic [31:0] m, e);
        int n;
        for (n = 0; n < 40 && (x_bits & m) !== e; n++)
            @(posedge sys_clk);
        chk(nm, e, x_bits & m);
    endtask
    // firmware side: see the channel busy, then post ok or fail
    task fw_done(input int c, input int fl);
        int n;
        for (n = 0; n < 10; n++)
        begin
            wb(0, 8'h00, 0);
            if (q[c] === 1'b1)
                break;
        end
        chk("busy", 32'h1, q[c]);
        wb(1, 8'h04, 32'h1 << (c + 8 * fl));
    endtask
    initial
    begin
        {rst, clk_en, wb_cyc_i, wb_stb_i, wb_we_i} = 5'b11000;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0000_0000;
        f = $urandom(7947);
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        chk("x_reset", 32'h0000_0000, x_bits);
        wb(0, 8'hfc, 0);
        chk("unmapped", 32'h0000_0000, q);
        // random flag settings; ready needs check passed and no watchdog
        repeat (8)
        begin
            f = $urandom % 16;
            wb(1, 8'h08, f);
            ex = {f[2], 2'b00, f[3] & !f[2], 2'b00, f[1], f[0], 24'h00_0000};
            wait_x("flags", 32'h9300_0000, ex);
        end
        wb(1, 8'h08, 8);
        wb(1, 8'h10, 32'h0001_0400);
        // every channel, ok or fail at random; send at the 1024 byte edge
        for (k = 0; k < 6; k++)
        begin
            f = $urandom % 2;
            rb = rbit[k];
            ex = (k == 0) ? (f ? 32'h2 : 32'h1) : 32'h1 << rb;
            fork
                cpu_model_inst.run(rb, k ? ex : 32'h3, 1'b1, seen);
                fw_done(k, f);
            join
            chk("done", ex, seen);
            chk("drop", 32'h0, x_bits & (k ? ex : 32'h3));
        end
        // lengths refused without firmware help
        foreach (bad[i])
        begin
            wb(1, 8'h10, bad[i]);
            cpu_model_inst.run(0, 32'h3, 1'b1, seen);
            chk("bad_len", 32'h2, seen);
        end
        wb(1, 8'h0c, 1);
        wait_x("rx_set", 32'h4, 32'h4);
        cpu_model_inst.run(2, 32'h4, 1'b0, seen);
        chk("rx_clear", 32'h0, x_bits & 32'h4);
        // clock enable low must freeze the confirm path until it returns
        wb(1, 8'h0c, 1);
        wait_x("rx_again", 32'h4, 32'h4);
        clk_en <= 1'b0;
        fork
            cpu_model_inst.run(2, 32'h4, 1'b0, seen);
            begin
                repeat (10) @(posedge sys_clk);
                chk("frozen", 32'h4, x_bits & 32'h4);
                clk_en <= 1'b1;
            end
        join
        chk("thawed", 32'h0, seen);
        wb(1, 8'h10, 32'h0002_0010);
        wb(1, 8'h0c, 2);
        wb(0, 8'h00, 0);
        chk("echo_set", 32'h1, q[10]);
        wb(1, 8'h04, 32'h0001_0000);
        wb(0, 8'h00, 0);
        chk("echo_sent", 32'h0, q[10]);
        give_verdict;
    end
endmodule // testbench
bind net_host_if net_host_sva net_host_sva_inst (.sys_clk, .rst, .clk_en, .y_bits, .x_bits,
    .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o);
